// [common/flt_defs.svh]
`ifndef FLT_DEFS_SVH
`define FLT_DEFS_SVH

// register indices; byte address is four times the index
`define FLT_IDX_CFG 7'h4a
`define FLT_IDX_OFFSET 7'h4e
`define FLT_IDX_LIMIT 7'h56
`define FLT_IDX_DUTY 7'h57
`define FLT_IDX_STATUS 7'h60

// reset values
`define FLT_RST_LIMIT 8'h7f
`define FLT_RST_DUTY 8'h3f
`define FLT_RST_CFG 8'h00
`define FLT_RST_OFFSET 8'h00

// config register bit positions
`define FLT_CFG_TEMP_HIRES 0
`define FLT_CFG_DUTY_HIRES 1
`define FLT_CFG_PWM_FAST 2
`define FLT_CFG_TABLE_WEN 5

// status register bit positions
`define FLT_ST_ACTIVE 8
`define FLT_ST_FAST 9

// field positions inside the entry registers
`define FLT_LIMIT_HALF 7
`define FLT_DUTY_EXT_LO 6

// remote reading layout: sign at bit 15, whole degrees 14:8
`define FLT_TEMP_SIGN 15

// latency from request to waitrequest low, in cycles
`define FLT_BUS_LATENCY 1

`endif

// [common/flt_pkg.sv]
package flt_pkg;

  // software-visible mode bits
  typedef struct packed {
    logic table_wen;
    logic pwm_fast;
    logic duty_hires;
    logic temp_hires;
  } flt_cfg_s;

  // one lookup entry: limit and paired duty
  typedef struct packed {
    logic limit_four_half_bit;
    logic [6:0] limit_four_degrees;
    logic [1:0] duty_four_extended;
    logic [5:0] duty_four_base;
  } flt_entry_s;

  typedef enum logic [0:0] {FLT_IDLE, FLT_ACK} flt_bus_e;

endpackage

// [rtl/flt_entry_four.sv]
`timescale 1ns/1ps
`include "flt_defs.svh"
// Summary of operation
// - Low-resolution temperature mode: limit bit 7 reads zero.
// - High-resolution limit is eight bits, half-degree steps; low-res whole degrees.
// - Reading above the limit selects the paired duty value for the fan.
// - Compare upper 9 reading bits in high-res, upper 8 in low-res.
// - Limit sign bit is always taken as zero.
// - Table offset register is added to the limit before comparing.
// - Low-resolution duty mode: duty bits 7:6 read zero.
// - High-resolution duty mode: bits 7:6 join bits 5:0 as duty.
// - Extended duty bits count only with the 22.5kHz PWM frequency.
// - Low-resolution duty mode: bits 5:0 alone give the duty.
module flt_entry_four
  import flt_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] remote_temp,
  output logic entry_active,
  output logic [7:0] fan_duty
);

  flt_entry_s entry;
  flt_cfg_s cfg;
  logic [7:0] lut_offset;
  flt_bus_e bus_state;
  logic [6:0] index;
  logic req;
  logic wr_take;
  logic next_active;
  logic [7:0] next_duty;
  logic [31:0] next_rdata;

  // all assertions below sample on the core clock and sleep during reset
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // limit as seen by software, bit 7 masked in low-res
  function automatic logic [7:0] limit_view(flt_entry_s e, flt_cfg_s c);
    limit_view = {e.limit_four_half_bit & c.temp_hires, e.limit_four_degrees};
  endfunction

  // duty as seen by software, bits 7:6 masked in low-res
  function automatic logic [7:0] duty_view(flt_entry_s e, flt_cfg_s c);
    duty_view = {e.duty_four_extended & {2{c.duty_hires}}, e.duty_four_base};
  endfunction

  // reading above limit plus offset, in half-degree units
  function automatic logic exceeds(logic [15:0] t, flt_entry_s e, flt_cfg_s c,
                                   logic [7:0] ofs);
    logic [9:0] lim;
    logic [9:0] rd;
    lim = 10'h000;
    rd = 10'h000;
    if (c.temp_hires) begin
      // sign forced zero, half bit is the lsb
      lim = {2'b00, e.limit_four_degrees, e.limit_four_half_bit};
      rd = {2'b00, t[14:7]};
    end else begin
      lim = {2'b00, e.limit_four_degrees, 1'b0};
      rd = {2'b00, t[14:8], 1'b0};
    end
    lim = lim + {1'b0, ofs, 1'b0};
    // a negative reading never exceeds a non-negative limit
    exceeds = !t[`FLT_TEMP_SIGN] && (rd > lim);
  endfunction

  assign index = avs_address[8:2];
  assign req = avs_read | avs_write;
  assign wr_take = avs_write & (bus_state == FLT_ACK);

  // one wait cycle, then the request is taken
  assign avs_waitrequest = req & (bus_state == FLT_IDLE);

  // bus handshake state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_state <= FLT_IDLE;
    end else begin
      case (bus_state)
        FLT_IDLE: begin
          if (req) begin
            bus_state <= FLT_ACK;
          end
        end
        FLT_ACK: bus_state <= FLT_IDLE;
        default: bus_state <= FLT_IDLE;
      endcase
    end
  end

  // mode configuration, always writable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg <= flt_cfg_s'(4'(`FLT_RST_CFG));
    end else if (wr_take && index == `FLT_IDX_CFG && avs_byteenable[0]) begin
      cfg.temp_hires <= avs_writedata[`FLT_CFG_TEMP_HIRES];
      cfg.duty_hires <= avs_writedata[`FLT_CFG_DUTY_HIRES];
      cfg.pwm_fast <= avs_writedata[`FLT_CFG_PWM_FAST];
      cfg.table_wen <= avs_writedata[`FLT_CFG_TABLE_WEN];
    end
  end

  // table temperature offset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lut_offset <= `FLT_RST_OFFSET;
    end else if (wr_take && index == `FLT_IDX_OFFSET && avs_byteenable[0]) begin
      lut_offset <= avs_writedata[7:0];
    end
  end

  // entry registers, guarded by the table write enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {entry.limit_four_half_bit, entry.limit_four_degrees} <= `FLT_RST_LIMIT;
      {entry.duty_four_extended, entry.duty_four_base} <= `FLT_RST_DUTY;
    end else if (wr_take && cfg.table_wen && avs_byteenable[0]) begin
      if (index == `FLT_IDX_LIMIT) begin
        {entry.limit_four_half_bit, entry.limit_four_degrees} <= avs_writedata[7:0];
      end
      if (index == `FLT_IDX_DUTY) begin
        {entry.duty_four_extended, entry.duty_four_base} <= avs_writedata[7:0];
      end
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (index)
      `FLT_IDX_CFG: begin
        next_rdata[`FLT_CFG_TEMP_HIRES] = cfg.temp_hires;
        next_rdata[`FLT_CFG_DUTY_HIRES] = cfg.duty_hires;
        next_rdata[`FLT_CFG_PWM_FAST] = cfg.pwm_fast;
        next_rdata[`FLT_CFG_TABLE_WEN] = cfg.table_wen;
      end
      `FLT_IDX_OFFSET: next_rdata[7:0] = lut_offset;
      `FLT_IDX_LIMIT: next_rdata[7:0] = limit_view(entry, cfg);
      `FLT_IDX_DUTY: next_rdata[7:0] = duty_view(entry, cfg);
      `FLT_IDX_STATUS: begin
        next_rdata[7:0] = fan_duty;
        next_rdata[`FLT_ST_ACTIVE] = entry_active;
        next_rdata[`FLT_ST_FAST] = cfg.pwm_fast;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured during the wait cycle, stable when taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_state == FLT_IDLE) begin
      avs_readdata <= next_rdata;
    end
  end

  // duty selection; extended bits need high-res duty and fast pwm
  always_comb begin
    next_active = exceeds(remote_temp, entry, cfg, lut_offset);
    if (cfg.duty_hires && cfg.pwm_fast) begin
      next_duty = {entry.duty_four_extended, entry.duty_four_base};
    end else begin
      // slow pwm cannot resolve the extra bits, so they are dropped
      next_duty = {2'b00, entry.duty_four_base};
    end
  end

  // registered fan outputs, one cycle behind the reading
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      entry_active <= 1'b0;
      fan_duty <= 8'h00;
    end else begin
      entry_active <= next_active;
      fan_duty <= next_active ? next_duty : 8'h00;
    end
  end

  // raw stored entry bytes, masks not applied, for the write checks
  logic [7:0] past_limit_raw;
  logic [7:0] past_duty_raw;
  assign past_limit_raw = {entry.limit_four_half_bit, entry.limit_four_degrees};
  assign past_duty_raw = {entry.duty_four_extended, entry.duty_four_base};

  a_limit_low_zero: assert property (
    avs_read && bus_state == FLT_IDLE && index == `FLT_IDX_LIMIT && !cfg.temp_hires
    |=> !avs_readdata[7])
    else $error("limit bit 7 read as one in low-res mode");

  a_duty_low_zero: assert property (
    avs_read && bus_state == FLT_IDLE && index == `FLT_IDX_DUTY && !cfg.duty_hires
    |=> avs_readdata[7:6] == 2'b00)
    else $error("duty bits 7:6 read nonzero in low-res mode");

  a_hires_half_step: assert property (
    cfg.temp_hires && lut_offset == 8'h00 && !remote_temp[`FLT_TEMP_SIGN]
    && remote_temp[14:7] == {entry.limit_four_degrees, entry.limit_four_half_bit} + 8'h01
    && entry.limit_four_degrees != 7'h7f
    |=> entry_active)
    else $error("half degree above limit not detected");

  a_low_ignores_half: assert property (
    !cfg.temp_hires && lut_offset == 8'h00
    && remote_temp[15:8] == {1'b0, entry.limit_four_degrees}
    |=> !entry_active)
    else $error("low-res compare used bits below the whole degree");

  a_negative_no_hit: assert property (
    remote_temp[`FLT_TEMP_SIGN] |=> !entry_active)
    else $error("negative reading selected entry four");

  a_offset_shifts: assert property (
    !cfg.temp_hires && !remote_temp[`FLT_TEMP_SIGN]
    && ({1'b0, remote_temp[14:8]} <= {1'b0, entry.limit_four_degrees} + {1'b0, lut_offset})
    |=> !entry_active)
    else $error("reading within offset limit selected entry four");

  a_duty_selected: assert property (
    next_active && cfg.duty_hires && cfg.pwm_fast
    |=> fan_duty == $past(duty_view(entry, cfg)) && entry_active)
    else $error("fan duty does not follow entry four duty");

  a_ext_needs_fast: assert property (
    !cfg.pwm_fast ##1 !cfg.pwm_fast |-> fan_duty[7:6] == 2'b00)
    else $error("extended duty bits used without fast pwm");

  a_low_duty_base: assert property (
    next_active && !cfg.duty_hires |=> fan_duty == {2'b00, $past(entry.duty_four_base)})
    else $error("low-res duty differs from base bits");

  a_write_locked: assert property (
    wr_take && !cfg.table_wen && index == `FLT_IDX_LIMIT
    |=> {entry.limit_four_half_bit, entry.limit_four_degrees} == $past(past_limit_raw))
    else $error("limit changed while table writes disabled");

  a_wait_bounded: assert property (
    req && bus_state == FLT_IDLE |=> !avs_waitrequest)
    else $error("waitrequest held beyond one cycle");

  // read-back views in the high-resolution modes
  a_hires_limit_read: assert property (
    avs_read && bus_state == FLT_IDLE && index == `FLT_IDX_LIMIT && cfg.temp_hires
    |=> avs_readdata[7:0] == $past(past_limit_raw))
    else $error("limit read back altered in high-res mode");

  a_hires_duty_read: assert property (
    avs_read && bus_state == FLT_IDLE && index == `FLT_IDX_DUTY && cfg.duty_hires
    |=> avs_readdata[7:0] == $past(past_duty_raw))
    else $error("duty read back altered in high-res mode");

  // compare end points; equality must never select the entry
  a_hires_equal_miss: assert property (
    cfg.temp_hires && lut_offset == 8'h00 && !remote_temp[`FLT_TEMP_SIGN]
    && remote_temp[14:7] == {entry.limit_four_degrees, entry.limit_four_half_bit}
    |=> !entry_active)
    else $error("reading equal to high-res limit selected entry four");

  a_offset_hit: assert property (
    !cfg.temp_hires && !remote_temp[`FLT_TEMP_SIGN]
    && ({1'b0, remote_temp[14:8]} > {1'b0, entry.limit_four_degrees} + {1'b0, lut_offset})
    |=> entry_active)
    else $error("reading above offset limit missed entry four");

  a_idle_duty_zero: assert property (
    !next_active |=> fan_duty == 8'h00 && !entry_active)
    else $error("fan duty driven while entry four not selected");

  // register write paths; a dropped byte lane 0 must leave every register alone
  a_limit_write_lands: assert property (
    wr_take && cfg.table_wen && avs_byteenable[0] && index == `FLT_IDX_LIMIT
    |=> past_limit_raw == $past(avs_writedata[7:0]))
    else $error("enabled limit write did not land");

  a_duty_write_lands: assert property (
    wr_take && cfg.table_wen && avs_byteenable[0] && index == `FLT_IDX_DUTY
    |=> past_duty_raw == $past(avs_writedata[7:0]))
    else $error("enabled duty write did not land");

  a_duty_locked: assert property (
    wr_take && !cfg.table_wen && index == `FLT_IDX_DUTY |=> $stable(past_duty_raw))
    else $error("duty changed while table writes disabled");

  a_lane_off_ignored: assert property (
    wr_take && !avs_byteenable[0]
    |=> $stable(past_limit_raw) && $stable(past_duty_raw)
    && $stable(cfg) && $stable(lut_offset))
    else $error("write with byte lane 0 off changed a register");

  a_cfg_write: assert property (
    wr_take && avs_byteenable[0] && index == `FLT_IDX_CFG
    |=> cfg.table_wen == $past(avs_writedata[`FLT_CFG_TABLE_WEN])
    && cfg.pwm_fast == $past(avs_writedata[`FLT_CFG_PWM_FAST]))
    else $error("config write did not land");

  // read data only moves in the wait cycle of a read
  a_readdata_hold: assert property (
    !(avs_read && bus_state == FLT_IDLE) |=> $stable(avs_readdata))
    else $error("read data changed outside a read wait cycle");

endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "flt_defs.svh"
module tb_top
  import flt_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] remote_temp = 16'h0000;
  logic entry_active;
  logic [7:0] fan_duty;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  flt_cfg_s cfg_now = '0;

  flt_entry_four dut_u (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .remote_temp(remote_temp),
    .entry_active(entry_active), .fan_duty(fan_duty));

  // 125 MHz core clock
  always #4 mclk = ~mclk;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, far above the under two hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access; entered just after a rising edge, leaves one edge after release
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    chk("wait_edges", `FLT_BUS_LATENCY + 1, n);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk("readdata", exp, r);
  endtask

  // config bits sit at 5, 2, 1, 0 of the byte
  task automatic set_cfg(input flt_cfg_s c);
    cfg_now = c;
    wr(`FLT_IDX_CFG, {2'b00, c.table_wen, 2'b00, c.pwm_fast, c.duty_hires, c.temp_hires});
  endtask

  // fan path is one cycle behind, so two edges settle it; status mirrors it
  task automatic fan_chk(input logic [15:0] t, input logic act, input logic [7:0] duty);
    remote_temp <= t;
    repeat (2) @(posedge mclk);
    chk("fan", {23'h0, act, duty}, {23'h0, entry_active, fan_duty});
    rdc(`FLT_IDX_STATUS, {22'h0, cfg_now.pwm_fast, act, duty});
  endtask

  task automatic t_reset();
    rdc(`FLT_IDX_LIMIT, 32'h7f);
    rdc(`FLT_IDX_DUTY, 32'h3f);
    rdc(`FLT_IDX_CFG, 32'h00);
    rdc(`FLT_IDX_OFFSET, 32'h00);
    rdc(7'h40, 32'h00);
    $display("test reset done");
  endtask

  task automatic t_access();
    wr(`FLT_IDX_LIMIT, 8'h10);
    rdc(`FLT_IDX_LIMIT, 32'h7f);
    set_cfg(4'b1000);
    wr(`FLT_IDX_LIMIT, 8'hb2);
    wr(`FLT_IDX_DUTY, 8'hc5);
    rdc(`FLT_IDX_LIMIT, 32'h32);
    rdc(`FLT_IDX_DUTY, 32'h05);
    set_cfg(4'b1011);
    rdc(`FLT_IDX_LIMIT, 32'hb2);
    rdc(`FLT_IDX_DUTY, 32'hc5);
    $display("test access done");
  endtask

  task automatic t_compare();
    set_cfg(4'b1000);
    fan_chk(16'h3280, 1'b0, 8'h00);
    fan_chk(16'h3300, 1'b1, 8'h05);
    set_cfg(4'b1001);
    fan_chk(16'h3280, 1'b0, 8'h00);
    fan_chk(16'h3300, 1'b1, 8'h05);
    fan_chk(16'hb300, 1'b0, 8'h00);
    $display("test compare done");
  endtask

  task automatic t_extended();
    set_cfg(4'b1011);
    fan_chk(16'h3300, 1'b1, 8'h05);
    set_cfg(4'b1111);
    fan_chk(16'h3300, 1'b1, 8'hc5);
    set_cfg(4'b1101);
    fan_chk(16'h3300, 1'b1, 8'h05);
    $display("test extended done");
  endtask

  task automatic t_offset();
    set_cfg(4'b1001);
    wr(`FLT_IDX_OFFSET, 8'h0a);
    fan_chk(16'h3c80, 1'b0, 8'h00);
    fan_chk(16'h3d00, 1'b1, 8'h05);
    $display("test offset done");
  endtask

  // byte lane 0 off and unmapped writes are dropped
  task automatic t_guard();
    set_cfg(4'b1000);
    avs_byteenable <= 4'h0;
    wr(`FLT_IDX_LIMIT, 8'h21);
    wr(`FLT_IDX_OFFSET, 8'h33);
    avs_byteenable <= 4'h1;
    rdc(`FLT_IDX_LIMIT, 32'h32);
    rdc(`FLT_IDX_OFFSET, 32'h0a);
    wr(7'h40, 8'h5a);
    rdc(7'h40, 32'h00);
    $display("test guard done");
  endtask

  // second reset in mid-run restores the registers and idles the fan
  task automatic t_rerun();
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("fan_in_reset", 32'h0, {23'h0, entry_active, fan_duty});
    rstn <= 1'b1;
    @(posedge mclk);
    cfg_now = '0;
    t_reset();
    wr(`FLT_IDX_DUTY, 8'h2a);
    rdc(`FLT_IDX_DUTY, 32'h3f);
    fan_chk(16'h7f00, 1'b0, 8'h00);
    $display("test rerun done");
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_access();
    t_compare();
    t_extended();
    t_offset();
    t_guard();
    t_rerun();
    close_out();
  end
endmodule
